//--- core/fepc_map.svh
// Address layout, field positions and fill values of the program flash.
// Included by every file of the flash controller except the package; definitions only.
`ifndef FEPC_MAP_SVH
`define FEPC_MAP_SVH

`define FEPC_ADDR_W      16
`define FEPC_DATA_W      32
`define FEPC_WADDR_W     14
`define FEPC_WORDS       16384
`define FEPC_WORD_LSB    2
`define FEPC_BLK_LSB     10
`define FEPC_BLK_W       6
`define FEPC_BOFF_W      8
`define FEPC_BOFF_LAST   8'hff
`define FEPC_UNIT_LSB    11
`define FEPC_UNIT_W      5
`define FEPC_UNITS       32
`define FEPC_ERASED_WORD 32'hffffffff
`define FEPC_ZERO_WORD   32'h00000000

`endif

//--- core/fepc_pkg.sv
// Types shared by the flash controller modules.
// Assumes nothing of its surroundings.
package fepc_pkg;

    typedef enum logic [1:0] {
        FEPC_ACC_FETCH,
        FEPC_ACC_DATA,
        FEPC_ACC_DEBUG
    } fepc_acc_type;

    typedef enum logic {
        FEPC_OP_ERASE,
        FEPC_OP_PROGRAM
    } fepc_op_type;

    typedef enum logic {
        FEPC_ST_IDLE,
        FEPC_ST_ERASING
    } fepc_state_type;

endpackage

//--- core/fepc_prot_if.sv
// Protection query between the flash controller and its permission checker.
// Assumes both ends run on the same clock; the path is purely combinational.
`timescale 1ns/1ps
`include "fepc_map.svh"

interface fepc_prot_if;
    import fepc_pkg::*;

    logic [`FEPC_UNITS-1:0]  ro_mark;
    logic [`FEPC_UNITS-1:0]  xo_mark;
    logic [`FEPC_UNIT_W-1:0] rd_unit;
    fepc_acc_type            rd_kind;
    logic [`FEPC_UNIT_W-1:0] wr_unit;
    logic                    rd_ok;
    logic                    wr_ok;

    modport ctrl (output ro_mark, xo_mark, rd_unit, rd_kind, wr_unit, input rd_ok, wr_ok);
    modport chk  (input ro_mark, xo_mark, rd_unit, rd_kind, wr_unit, output rd_ok, wr_ok);
endinterface

//--- core/fepc_prot_chk.sv
// Permission checker for reads and for erase/program requests.
// Assumes the controller presents unit indices and markings on the same clock.
`timescale 1ns/1ps
`include "fepc_map.svh"

module fepc_prot_chk
    import fepc_pkg::*;
(
    fepc_prot_if.chk pif
);

    // Only instruction fetches may look inside an execute-only pair
    always_comb begin
        pif.rd_ok = !pif.xo_mark[pif.rd_unit] || (pif.rd_kind == FEPC_ACC_FETCH);
    end

    // Either marking locks the pair against erase and program
    always_comb begin
        pif.wr_ok = !(pif.ro_mark[pif.wr_unit] || pif.xo_mark[pif.wr_unit]);
    end

endmodule

//--- core/fepc_ctrl.sv
// Program flash controller: single-cycle reads, per-block erase, word program,
// and pair-wise read-only / execute-only protection.
// Assumes requesters and protection markings run on clk_sys; no pin inputs.
`timescale 1ns/1ps
`include "fepc_map.svh"

module fepc_ctrl
    import fepc_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    input  wire logic [`FEPC_UNITS-1:0]   prot_ro,
    input  wire logic [`FEPC_UNITS-1:0]   prot_xo,
    input  wire logic                     rd_req,
    input  fepc_acc_type                  rd_kind,
    input  wire logic [`FEPC_ADDR_W-1:0]  rd_addr,
    output logic                          rd_valid,
    output logic [`FEPC_DATA_W-1:0]       rd_data,
    output logic                          rd_denied,
    input  wire logic                     op_req,
    input  fepc_op_type                   op_kind,
    input  wire logic [`FEPC_ADDR_W-1:0]  op_addr,
    input  wire logic [`FEPC_DATA_W-1:0]  op_data,
    output logic                          op_busy,
    output logic                          op_done,
    output logic                          op_refused
);

    logic [`FEPC_DATA_W-1:0]  flash_mem [`FEPC_WORDS];
    fepc_state_type           state_reg;
    logic [`FEPC_BLK_W-1:0]   erase_blk_reg;
    logic [`FEPC_BOFF_W-1:0]  erase_cnt_reg;
    logic                     rd_valid_reg;
    logic [`FEPC_DATA_W-1:0]  rd_data_reg;
    logic                     rd_denied_reg;
    logic                     op_busy_reg;
    logic                     op_done_reg;
    logic                     op_refused_reg;

    logic                     op_take;
    logic                     erase_start;
    logic                     prog_we;
    logic                     erase_we;
    logic                     mem_we;
    logic [`FEPC_WADDR_W-1:0] mem_waddr;
    logic [`FEPC_DATA_W-1:0]  mem_wdata;
    logic [`FEPC_WADDR_W-1:0] op_waddr;

    fepc_prot_if pif ();

    // Unit index is the byte address above the 2-KB boundary
    assign pif.ro_mark = prot_ro;
    assign pif.xo_mark = prot_xo;
    assign pif.rd_unit = rd_addr[`FEPC_ADDR_W-1:`FEPC_UNIT_LSB];
    assign pif.wr_unit = op_addr[`FEPC_ADDR_W-1:`FEPC_UNIT_LSB];
    assign pif.rd_kind = rd_kind;

    fepc_prot_chk u_chk (
        .pif (pif.chk)
    );

    // Requests arriving while an erase runs are dropped, not queued
    assign op_take     = op_req && !op_busy_reg;
    assign erase_start = op_take && (op_kind == FEPC_OP_ERASE) && pif.wr_ok;
    assign prog_we     = op_take && (op_kind == FEPC_OP_PROGRAM) && pif.wr_ok;
    assign erase_we    = (state_reg == FEPC_ST_ERASING);
    assign mem_we      = erase_we || prog_we;
    assign op_waddr    = op_addr[`FEPC_ADDR_W-1:`FEPC_WORD_LSB];

    // Erase walks one word per cycle, only inside the latched block
    always_comb begin
        if (erase_we) begin
            mem_waddr = {erase_blk_reg, erase_cnt_reg};
            mem_wdata = `FEPC_ERASED_WORD;
        end else begin
            mem_waddr = op_waddr;
            // Programming can only clear bits, as a real cell would
            mem_wdata = flash_mem[op_waddr] & op_data;
        end
    end

    // Array has no reset; contents are whatever was last erased or programmed
    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            flash_mem[mem_waddr] <= mem_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg     <= FEPC_ST_IDLE;
            erase_blk_reg <= '0;
            erase_cnt_reg <= '0;
        end else begin
            case (state_reg)
                FEPC_ST_IDLE: begin
                    if (erase_start) begin
                        state_reg     <= FEPC_ST_ERASING;
                        erase_blk_reg <= op_addr[`FEPC_ADDR_W-1:`FEPC_BLK_LSB];
                        erase_cnt_reg <= '0;
                    end
                end
                FEPC_ST_ERASING: begin
                    erase_cnt_reg <= erase_cnt_reg + 8'h01;
                    if (erase_cnt_reg == `FEPC_BOFF_LAST) begin
                        state_reg <= FEPC_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= FEPC_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            op_busy_reg    <= 1'b0;
            op_done_reg    <= 1'b0;
            op_refused_reg <= 1'b0;
        end else begin
            op_refused_reg <= op_take && !pif.wr_ok;
            if (erase_start) begin
                op_busy_reg <= 1'b1;
            end else if (erase_we && (erase_cnt_reg == `FEPC_BOFF_LAST)) begin
                op_busy_reg <= 1'b0;
            end
            op_done_reg <= prog_we || (erase_we && (erase_cnt_reg == `FEPC_BOFF_LAST));
        end
    end

    // Read port never stalls, even during an erase
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_valid_reg  <= 1'b0;
            rd_data_reg   <= `FEPC_ZERO_WORD;
            rd_denied_reg <= 1'b0;
        end else begin
            rd_valid_reg  <= rd_req;
            rd_denied_reg <= rd_req && !pif.rd_ok;
            if (rd_req && pif.rd_ok) begin
                rd_data_reg <= flash_mem[rd_addr[`FEPC_ADDR_W-1:`FEPC_WORD_LSB]];
            end else begin
                rd_data_reg <= `FEPC_ZERO_WORD;
            end
        end
    end

    assign rd_valid   = rd_valid_reg;
    assign rd_data    = rd_data_reg;
    assign rd_denied  = rd_denied_reg;
    assign op_busy    = op_busy_reg;
    assign op_done    = op_done_reg;
    assign op_refused = op_refused_reg;

    // Checks

    logic [`FEPC_UNIT_W-1:0] rd_u;
    logic [`FEPC_UNIT_W-1:0] op_u;
    assign rd_u = rd_addr[`FEPC_ADDR_W-1:`FEPC_UNIT_LSB];
    assign op_u = op_addr[`FEPC_ADDR_W-1:`FEPC_UNIT_LSB];

    sequence s_erase_run;
        op_busy [*8];
    endsequence

    sequence s_erase_end;
        ##249 op_done && !op_busy;
    endsequence

    property p_erase_in_block;
        @(posedge clk_sys) disable iff (srst)
        erase_we |-> op_busy && !prog_we && (mem_waddr[`FEPC_WADDR_W-1:`FEPC_BOFF_W] == erase_blk_reg);
    endproperty
    a_erase_in_block: assert property (p_erase_in_block)
        else $error("Erase wrote outside its block");

    property p_erase_time;
        @(posedge clk_sys) disable iff (srst)
        erase_start |=> s_erase_run ##0 s_erase_end;
    endproperty
    a_erase_time: assert property (p_erase_time)
        else $error("Erase did not take one block of cycles");

    property p_erase_ones;
        @(posedge clk_sys) disable iff (srst)
        erase_we |-> (mem_we && mem_wdata == `FEPC_ERASED_WORD);
    endproperty
    a_erase_ones: assert property (p_erase_ones)
        else $error("Erase wrote a word that is not all ones");

    property p_pair_unit;
        @(posedge clk_sys) disable iff (srst)
        rd_req && rd_kind == FEPC_ACC_DEBUG && !prot_xo[rd_u] |=> rd_valid && !rd_denied;
    endproperty
    a_pair_unit: assert property (p_pair_unit)
        else $error("Read denied outside an execute-only pair");

    property p_ro_readable;
        @(posedge clk_sys) disable iff (srst)
        rd_req && prot_ro[rd_u] && !prot_xo[rd_u] |=> !rd_denied;
    endproperty
    a_ro_readable: assert property (p_ro_readable)
        else $error("Read-only pair refused a read");

    property p_ro_locked;
        @(posedge clk_sys) disable iff (srst)
        op_req && !op_busy && prot_ro[op_u] |-> !prog_we && !erase_start ##1 op_refused && !op_done && !op_busy;
    endproperty
    a_ro_locked: assert property (p_ro_locked)
        else $error("Read-only pair accepted a change");

    property p_xo_locked;
        @(posedge clk_sys) disable iff (srst)
        op_req && !op_busy && prot_xo[op_u] |-> !prog_we && !erase_start ##1 op_refused && !op_busy;
    endproperty
    a_xo_locked: assert property (p_xo_locked)
        else $error("Execute-only pair accepted a change");

    property p_xo_reads;
        @(posedge clk_sys) disable iff (srst)
        rd_req && prot_xo[rd_u] && rd_kind != FEPC_ACC_FETCH |=> rd_denied && rd_data == `FEPC_ZERO_WORD;
    endproperty
    a_xo_reads: assert property (p_xo_reads)
        else $error("Execute-only pair leaked to a non-fetch read");

    property p_one_cycle;
        @(posedge clk_sys) disable iff (srst)
        rd_req |=> rd_valid ##1 (rd_valid == $past(rd_req));
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("Read answer not one cycle after request");

    property p_unmarked_open;
        @(posedge clk_sys) disable iff (srst)
        op_req && !op_busy && !prot_ro[op_u] && !prot_xo[op_u] |=> !op_refused && (op_done || op_busy);
    endproperty
    a_unmarked_open: assert property (p_unmarked_open)
        else $error("Unmarked pair refused a change");

endmodule

//--- verif/fepc_host_mdl.sv
// Requester model: fetch, data and debugger reads plus erase/program requests.
// Assumes the controller samples on rising clk_sys; this model drives on the falling edge.
`timescale 1ns/1ps
`include "fepc_map.svh"

module fepc_host_mdl
    import fepc_pkg::*;
(
    input  wire logic                    clk_sys,
    output logic                         rd_req,
    output fepc_acc_type                 rd_kind,
    output logic [`FEPC_ADDR_W-1:0]      rd_addr,
    input  wire logic                    rd_valid,
    input  wire logic [`FEPC_DATA_W-1:0] rd_data,
    input  wire logic                    rd_denied,
    output logic                         op_req,
    output fepc_op_type                  op_kind,
    output logic [`FEPC_ADDR_W-1:0]      op_addr,
    output logic [`FEPC_DATA_W-1:0]      op_data,
    input  wire logic                    op_busy,
    input  wire logic                    op_done,
    input  wire logic                    op_refused
);
    initial begin
        rd_req  = 1'b0;
        rd_kind = FEPC_ACC_FETCH;
        rd_addr = 16'h0000;
        op_req  = 1'b0;
        op_kind = FEPC_OP_ERASE;
        op_addr = 16'h0000;
        op_data = 32'h00000000;
    end

    // Released address and data lines are inverted so a stale value cannot pass for a held one
    task automatic read(input fepc_acc_type k, input logic [15:0] a,
                        output logic v, output logic [31:0] d, output logic dn);
        @(negedge clk_sys);
        rd_req  = 1'b1;
        rd_kind = k;
        rd_addr = a;
        @(negedge clk_sys);
        rd_req  = 1'b0;
        rd_addr = ~a;
        v       = rd_valid;
        d       = rd_data;
        dn      = rd_denied;
    endtask

    task automatic op(input fepc_op_type k, input logic [15:0] a, input logic [31:0] w,
                      output logic bz, output logic dn, output logic rf, output int n);
        @(negedge clk_sys);
        op_req  = 1'b1;
        op_kind = k;
        op_addr = a;
        op_data = w;
        @(negedge clk_sys);
        op_req  = 1'b0;
        op_addr = ~a;
        op_data = ~w;
        bz      = op_busy;
        dn      = op_done;
        rf      = op_refused;
        n       = 0;
        while (op_busy === 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        if (n > 0) dn = op_done;
    endtask
endmodule

//--- verif/fepc_ctrl_bench.sv
// Self-checking bench for the flash controller: erase, program, protection, reads.
// Assumes the requester model drives all request ports; markings are driven here.
`timescale 1ns/1ps
`include "fepc_map.svh"

module fepc_ctrl_bench;
    import fepc_pkg::*;

    logic                    clk_sys;
    logic                    srst;
    logic [`FEPC_UNITS-1:0]  prot_ro;
    logic [`FEPC_UNITS-1:0]  prot_xo;
    logic                    rd_req;
    fepc_acc_type            rd_kind;
    logic [`FEPC_ADDR_W-1:0] rd_addr;
    logic                    rd_valid;
    logic [`FEPC_DATA_W-1:0] rd_data;
    logic                    rd_denied;
    logic                    op_req;
    fepc_op_type             op_kind;
    logic [`FEPC_ADDR_W-1:0] op_addr;
    logic [`FEPC_DATA_W-1:0] op_data;
    logic                    op_busy;
    logic                    op_done;
    logic                    op_refused;
    int                      n_errors;
    int                      cmp_count;

    fepc_ctrl DUT (.clk_sys(clk_sys), .srst(srst), .prot_ro(prot_ro), .prot_xo(prot_xo),
        .rd_req(rd_req), .rd_kind(rd_kind), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .rd_denied(rd_denied), .op_req(op_req), .op_kind(op_kind),
        .op_addr(op_addr), .op_data(op_data), .op_busy(op_busy), .op_done(op_done),
        .op_refused(op_refused));

    fepc_host_mdl host (.clk_sys(clk_sys), .rd_req(rd_req), .rd_kind(rd_kind),
        .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .rd_denied(rd_denied),
        .op_req(op_req), .op_kind(op_kind), .op_addr(op_addr), .op_data(op_data),
        .op_busy(op_busy), .op_done(op_done), .op_refused(op_refused));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic do_read(input fepc_acc_type k, input logic [15:0] a, input logic [31:0] ed,
                           input logic eden);
        logic v, dn;
        logic [31:0] d;
        host.read(k, a, v, d, dn);
        chk_bit("rd_valid", 1'b1, v);
        chk_word("rd_data", ed, d);
        chk_bit("rd_denied", eden, dn);
    endtask

    task automatic do_op(input fepc_op_type k, input logic [15:0] a, input logic [31:0] w,
                         input logic refd);
        logic bz, dn, rf;
        int n;
        logic ebz;
        ebz = !refd && k == FEPC_OP_ERASE;
        host.op(k, a, w, bz, dn, rf, n);
        chk_bit("op_busy", ebz, bz);
        chk_bit("op_done", !refd, dn);
        chk_bit("op_refused", refd, rf);
        chk_word("busy_cycles", ebz ? 32'h00000100 : 32'h00000000, 32'(n));
    endtask

    task automatic t_erase_indep();
        do_op(FEPC_OP_ERASE, 16'h0000, 32'h0, 1'b0);
        do_op(FEPC_OP_ERASE, 16'h0400, 32'h0, 1'b0);
        do_op(FEPC_OP_PROGRAM, 16'h0404, 32'ha5a5a5a5, 1'b0);
        do_read(FEPC_ACC_DATA, 16'h0404, 32'ha5a5a5a5, 1'b0);
        do_op(FEPC_OP_ERASE, 16'h0000, 32'h0, 1'b0);
        do_read(FEPC_ACC_DATA, 16'h0000, 32'hffffffff, 1'b0);
        do_read(FEPC_ACC_DEBUG, 16'h03fc, 32'hffffffff, 1'b0);
        do_read(FEPC_ACC_DATA, 16'h0404, 32'ha5a5a5a5, 1'b0);
    endtask

    task automatic t_read_only();
        @(negedge clk_sys);
        prot_ro = 32'h00000001;
        do_op(FEPC_OP_ERASE, 16'h0400, 32'h0, 1'b1);
        do_op(FEPC_OP_PROGRAM, 16'h0404, 32'h0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            do_read(fepc_acc_type'(i), 16'h0404, 32'ha5a5a5a5, 1'b0);
        end
        prot_ro = 32'h00000000;
    endtask

    task automatic t_exec_only();
        @(negedge clk_sys);
        prot_xo = 32'h00000001;
        do_op(FEPC_OP_ERASE, 16'h0000, 32'h0, 1'b1);
        do_op(FEPC_OP_PROGRAM, 16'h0404, 32'h0, 1'b1);
        do_read(FEPC_ACC_FETCH, 16'h0404, 32'ha5a5a5a5, 1'b0);
        do_read(FEPC_ACC_DATA, 16'h0404, 32'h00000000, 1'b1);
        do_read(FEPC_ACC_DEBUG, 16'h07fc, 32'h00000000, 1'b1);
        do_op(FEPC_OP_ERASE, 16'h0800, 32'h0, 1'b0);
        do_read(FEPC_ACC_DEBUG, 16'h0800, 32'hffffffff, 1'b0);
        prot_xo = 32'h00000000;
        do_read(FEPC_ACC_DEBUG, 16'h0000, 32'hffffffff, 1'b0);
    endtask

    initial begin
        n_errors  = 0;
        cmp_count = 0;
        srst      = 1'b1;
        prot_ro   = 32'h00000000;
        prot_xo   = 32'h00000000;
        repeat (4) @(negedge clk_sys);
        srst = 1'b0;
        chk_bit("op_busy", 1'b0, op_busy);
        chk_bit("rd_valid", 1'b0, rd_valid);
        chk_bit("op_done", 1'b0, op_done);
        chk_bit("op_refused", 1'b0, op_refused);
        t_erase_indep();
        t_read_only();
        t_exec_only();
        finish_test();
    end

    // Four erases of 256 cycles plus short reads fit well inside this span
    initial begin
        #(3000 * 100);
        n_errors++;
        finish_test();
    end
endmodule
